// ===== mem_bus_model.sv
// memory bus model taking single-word stores from the decoder
// assumes memWrite is held until accepted; fetchRequest blocks acceptance
`timescale 1ns/1ps
`default_nettype none
module mem_bus_model (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        memWrite,
  input  wire logic [31:0] memAddr,
  input  wire logic [31:0] memWdata,
  input  wire logic        fetchRequest,
  input  wire logic [3:0]  waitCycles,
  output logic             memReady,
  output logic [31:0]      lastAddr,
  output logic [31:0]      lastData,
  output logic [7:0]       wrCount
);
  logic [3:0] waited;

  // ready only after waitCycles of a pending store, low when idle
  assign memReady = memWrite && (waited >= waitCycles);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      waited <= 4'h0;
      lastAddr <= 32'h0000_0000;
      lastData <= 32'h0000_0000;
      wrCount <= 8'h00;
    end else if (memWrite && memReady && !fetchRequest) begin
      waited <= 4'h0;
      lastAddr <= memAddr;
      lastData <= memWdata;
      wrCount <= wrCount + 8'h01;
    end else if (memWrite && !memReady) begin
      waited <= waited + 4'h1;
    end
  end
endmodule : mem_bus_model
`default_nettype wire

// ===== sysreg_decode_if.sv
// decoded instruction fields passed from decoder to execute control
// assumes a single clock domain
`timescale 1ns/1ps
`default_nettype none
interface sysreg_decode_if;
  logic                       valid;
  logic                       pushOp;
  logic                       regOp;
  logic                       trapOp;
  logic                       privileged;
  sysreg_store_pkg::src_sel_t srcSel;
  logic [2:0]                 bankIdx;
  logic [3:0]                 destIdx;
  logic [7:0]                 trapImm;
  logic [3:0]                 minCycles;
  modport decoder (output valid, pushOp, regOp, trapOp, privileged, srcSel, bankIdx,
                   destIdx, trapImm, minCycles);
  modport exec (input valid, pushOp, regOp, trapOp, privileged, srcSel, bankIdx,
                destIdx, trapImm, minCycles);
endinterface : sysreg_decode_if
`default_nettype wire

// ===== sysreg_decoder.sv
// combinational opcode decoder for store and trap instructions
// assumes the opcode is stable while valid is high
`timescale 1ns/1ps
`default_nettype none
module sysreg_decoder (
  input  wire logic [15:0]   opcode,
  input  wire logic          opValid,
  sysreg_decode_if.decoder   dec
);
  logic [3:0] hi;
  logic [3:0] mid;
  logic [3:0] lo;
  assign hi  = opcode[15:12];
  assign mid = opcode[7:4];
  assign lo  = opcode[3:0];

  always_comb begin
    dec.valid      = 1'b0;
    dec.pushOp     = 1'b0;
    dec.regOp      = 1'b0;
    dec.trapOp     = 1'b0;
    dec.privileged = 1'b0;
    dec.srcSel     = sysreg_store_pkg::SRC_NONE;
    dec.bankIdx    = opcode[6:4];
    dec.destIdx    = opcode[11:8];
    dec.trapImm    = opcode[7:0];
    dec.minCycles  = sysreg_store_pkg::CYC_REG;
    if (opValid && opcode[15:8] == sysreg_store_pkg::OP_TRAP_HI) begin
      dec.trapOp    = 1'b1;
      dec.minCycles = sysreg_store_pkg::CYC_TRAP;
    end else if (opValid && hi == sysreg_store_pkg::OP_GRP4
                 && lo == sysreg_store_pkg::LO_CTRL) begin
      dec.pushOp    = 1'b1;
      dec.minCycles = sysreg_store_pkg::CYC_CTRL;
      if (mid[3]) begin
        dec.srcSel     = sysreg_store_pkg::SRC_BANK;
        dec.privileged = 1'b1;
      end else if (mid <= 4'h4) begin
        dec.srcSel = sysreg_store_pkg::src_sel_t'(mid);
      end else begin
        dec.pushOp = 1'b0;
      end
    end else if (opValid && hi == sysreg_store_pkg::OP_GRP4
                 && lo == sysreg_store_pkg::LO_SYS_PUSH && mid <= 4'h2) begin
      dec.pushOp    = 1'b1;
      dec.minCycles = sysreg_store_pkg::CYC_SYS;
      dec.srcSel    = sysreg_store_pkg::src_sel_t'(mid + 4'h5);
    end else if (opValid && hi == sysreg_store_pkg::OP_GRP0
                 && lo == sysreg_store_pkg::LO_CTRL_REG) begin
      dec.regOp = 1'b1;
      if (mid[3]) begin
        dec.srcSel     = sysreg_store_pkg::SRC_BANK;
        dec.privileged = 1'b1;
      end else if (mid <= 4'h4) begin
        dec.srcSel = sysreg_store_pkg::src_sel_t'(mid);
      end else begin
        dec.regOp = 1'b0;
      end
    end else if (opValid && hi == sysreg_store_pkg::OP_GRP0
                 && lo == sysreg_store_pkg::LO_SYS_REG && mid <= 4'h2) begin
      dec.regOp  = 1'b1;
      dec.srcSel = sysreg_store_pkg::src_sel_t'(mid + 4'h5);
    end
    dec.valid = dec.pushOp | dec.regOp | dec.trapOp;
  end
endmodule : sysreg_decoder
`default_nettype wire

// ===== sysreg_store_pkg.sv
// constants for the system-register store decoder
// assumes 16-bit instruction words and a 32-bit data path
package sysreg_store_pkg;
  localparam logic [3:0]  OP_GRP0      = 4'h0;
  localparam logic [3:0]  OP_GRP4      = 4'h4;
  localparam logic [7:0]  OP_TRAP_HI   = 8'hC3;
  localparam logic [3:0]  LO_CTRL      = 4'h3;
  localparam logic [3:0]  LO_SYS_PUSH  = 4'h2;
  localparam logic [3:0]  LO_SYS_REG   = 4'hA;
  localparam logic [3:0]  LO_CTRL_REG  = 4'h2;
  localparam logic [31:0] PREDEC_STEP  = 32'h0000_0004;
  localparam logic [3:0]  CYC_CTRL     = 4'h2;
  localparam logic [3:0]  CYC_SYS      = 4'h1;
  localparam logic [3:0]  CYC_REG      = 4'h1;
  localparam logic [3:0]  CYC_TRAP     = 4'h8;
  localparam logic [1:0]  SZ_BYTE      = 2'h0;
  localparam logic [1:0]  SZ_WORD      = 2'h1;
  localparam logic [1:0]  SZ_LONG      = 2'h2;
  localparam int          DISP_SHORT_W = 4;
  localparam int          DISP_MID_W   = 8;
  localparam int          DISP_LONG_W  = 12;

  typedef enum logic [3:0] {
    SRC_STATUS  = 4'h0,
    SRC_GBASE   = 4'h1,
    SRC_VBASE   = 4'h2,
    SRC_SSTATUS = 4'h3,
    SRC_SPC     = 4'h4,
    SRC_MULTIPLY_ACC_HIGH    = 4'h5,
    SRC_MULTIPLY_ACC_LOW    = 4'h6,
    SRC_LINK    = 4'h7,
    SRC_BANK    = 4'h8,
    SRC_NONE    = 4'hF
  } src_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1,
    ST_WAIT = 2'h2
  } exec_state_t;
endpackage : sysreg_store_pkg

// ===== system_register_store_decode.sv
// execute control for system-register stores and the software trap
// assumes register values are supplied by the core and held during execution
`timescale 1ns/1ps
`default_nettype none
module system_register_store_decode #(
  parameter int DATA_W = 32
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic [15:0]       opcode,
  input  wire logic              opValid,
  output logic                   opReady,
  input  wire logic              privMode,
  input  wire logic [DATA_W-1:0] pcValue,
  input  wire logic [DATA_W-1:0] statusWord,
  input  wire logic [DATA_W-1:0] globalBase,
  input  wire logic [DATA_W-1:0] vectorBase,
  input  wire logic [DATA_W-1:0] savedStatusIn,
  input  wire logic [DATA_W-1:0] savedPcIn,
  input  wire logic [DATA_W-1:0] multiplyAccHigh,
  input  wire logic [DATA_W-1:0] multiplyAccLow,
  input  wire logic [DATA_W-1:0] returnLink,
  input  wire logic [DATA_W-1:0] bankedGpr [8],
  input  wire logic [DATA_W-1:0] destGprValue,
  input  wire logic              fetchRequest,
  input  wire logic              loadPending,
  input  wire logic [3:0]        loadDestIdx,
  input  wire logic              memReady,
  output logic                   memWrite,
  output logic [DATA_W-1:0]      memAddr,
  output logic [DATA_W-1:0]      memWdata,
  output logic                   gprWrite,
  output logic [3:0]             gprIdx,
  output logic [DATA_W-1:0]      gprWdata,
  output logic                   savedWrite,
  output logic [DATA_W-1:0]      savedPc,
  output logic [DATA_W-1:0]      savedStatus,
  output logic [7:0]             softwareExceptionCode,
  output logic                   illegalInstr,
  output logic                   busy,
  input  wire logic [11:0]       dispField,
  input  wire logic [1:0]        dispMode,
  input  wire logic [1:0]        operandSize,
  input  wire logic [DATA_W-1:0] dispBase,
  output logic [DATA_W-1:0]      effAddr
);
  sysreg_decode_if dec ();

  sysreg_decoder u_dec (
    .opcode  (opcode),
    .opValid (opValid),
    .dec     (dec)
  );

  function automatic logic [DATA_W-1:0] pickSource(
    input sysreg_store_pkg::src_sel_t sel,
    input logic [2:0]                 bank
  );
    case (sel)
      sysreg_store_pkg::SRC_STATUS:  pickSource = statusWord;
      sysreg_store_pkg::SRC_GBASE:   pickSource = globalBase;
      sysreg_store_pkg::SRC_VBASE:   pickSource = vectorBase;
      sysreg_store_pkg::SRC_SSTATUS: pickSource = savedStatusIn;
      sysreg_store_pkg::SRC_SPC:     pickSource = savedPcIn;
      sysreg_store_pkg::SRC_MULTIPLY_ACC_HIGH:    pickSource = multiplyAccHigh;
      sysreg_store_pkg::SRC_MULTIPLY_ACC_LOW:    pickSource = multiplyAccLow;
      sysreg_store_pkg::SRC_LINK:    pickSource = returnLink;
      sysreg_store_pkg::SRC_BANK:    pickSource = bankedGpr[bank];
      default:                       pickSource = '0;
    endcase
  endfunction : pickSource

  // displacement scaling and sign handling
  always_comb begin
    logic [DATA_W-1:0] disp;
    disp = '0;
    case (dispMode)
      2'h0: disp = DATA_W'(dispField[3:0]);
      2'h1: disp = DATA_W'(dispField[7:0]);
      2'h2: disp = DATA_W'(signed'(dispField[7:0]));
      default: disp = DATA_W'(signed'(dispField));
    endcase
    if (operandSize == sysreg_store_pkg::SZ_WORD) begin
      disp = disp << 1;
    end else if (operandSize == sysreg_store_pkg::SZ_LONG) begin
      disp = disp << 2;
    end
    effAddr = dispBase + disp;
  end

  sysreg_store_pkg::exec_state_t state;
  sysreg_store_pkg::exec_state_t next_state;
  logic [3:0]        cnt;
  logic [3:0]        next_cnt;
  logic              next_memWrite;
  logic [DATA_W-1:0] next_memAddr;
  logic [DATA_W-1:0] next_memWdata;
  logic              next_gprWrite;
  logic [3:0]        next_gprIdx;
  logic [DATA_W-1:0] next_gprWdata;
  logic              next_savedWrite;
  logic [DATA_W-1:0] next_savedPc;
  logic [DATA_W-1:0] next_savedStatus;
  logic [7:0]        next_code;
  logic              next_illegal;
  logic              hazard;
  logic              contend;

  // load-use hazard on the destination register
  assign hazard  = loadPending && dec.valid && (loadDestIdx == dec.destIdx);
  assign contend = fetchRequest && memWrite;
  assign opReady = (state == sysreg_store_pkg::ST_IDLE) && !hazard;
  assign busy    = (state != sysreg_store_pkg::ST_IDLE);

  always_comb begin
    next_state       = state;
    next_cnt         = cnt;
    next_memWrite    = memWrite;
    next_memAddr     = memAddr;
    next_memWdata    = memWdata;
    next_gprWrite    = 1'b0;
    next_gprIdx      = gprIdx;
    next_gprWdata    = gprWdata;
    next_savedWrite  = 1'b0;
    next_savedPc     = savedPc;
    next_savedStatus = savedStatus;
    next_code        = softwareExceptionCode;
    next_illegal     = 1'b0;
    case (state)
      sysreg_store_pkg::ST_IDLE: begin
        if (dec.valid && !hazard) begin
          if (dec.privileged && !privMode) begin
            next_illegal = 1'b1;
          end else if (dec.trapOp) begin
            next_savedPc     = pcValue;
            next_savedStatus = statusWord;
            next_code        = dec.trapImm;
            next_savedWrite  = 1'b1;
            next_cnt         = dec.minCycles;
            next_state       = sysreg_store_pkg::ST_WAIT;
          end else if (dec.regOp) begin
            next_gprWrite = 1'b1;
            next_gprIdx   = dec.destIdx;
            next_gprWdata = pickSource(dec.srcSel, dec.bankIdx);
          end else begin
            // predecrement then store at the new address
            next_gprWrite = 1'b1;
            next_gprIdx   = dec.destIdx;
            next_gprWdata = destGprValue - sysreg_store_pkg::PREDEC_STEP;
            next_memWrite = 1'b1;
            next_memAddr  = destGprValue - sysreg_store_pkg::PREDEC_STEP;
            next_memWdata = pickSource(dec.srcSel, dec.bankIdx);
            next_cnt      = dec.minCycles - 4'h1;
            next_state    = sysreg_store_pkg::ST_EXEC;
          end
        end
      end
      sysreg_store_pkg::ST_EXEC: begin
        if (memReady && !contend) begin
          // cycles left of the minimum run in the wait state
          next_memWrite = 1'b0;
          next_state    = (cnt > 4'h0) ? sysreg_store_pkg::ST_WAIT
                                       : sysreg_store_pkg::ST_IDLE;
          next_cnt      = (cnt > 4'h0) ? cnt - 4'h1 : 4'h0;
        end
      end
      sysreg_store_pkg::ST_WAIT: begin
        if (cnt <= 4'h1) begin
          next_state = sysreg_store_pkg::ST_IDLE;
          next_cnt   = 4'h0;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      default: next_state = sysreg_store_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state                 <= sysreg_store_pkg::ST_IDLE;
      cnt                   <= 4'h0;
      memWrite              <= 1'b0;
      memAddr               <= '0;
      memWdata              <= '0;
      gprWrite              <= 1'b0;
      gprIdx                <= 4'h0;
      gprWdata              <= '0;
      savedWrite            <= 1'b0;
      savedPc               <= '0;
      savedStatus           <= '0;
      softwareExceptionCode <= 8'h00;
      illegalInstr          <= 1'b0;
    end else begin
      state                 <= next_state;
      cnt                   <= next_cnt;
      memWrite              <= next_memWrite;
      memAddr               <= next_memAddr;
      memWdata              <= next_memWdata;
      gprWrite              <= next_gprWrite;
      gprIdx                <= next_gprIdx;
      gprWdata              <= next_gprWdata;
      savedWrite            <= next_savedWrite;
      savedPc               <= next_savedPc;
      savedStatus           <= next_savedStatus;
      softwareExceptionCode <= next_code;
      illegalInstr          <= next_illegal;
    end
  end

  // cycles spent inside a trap, for the length check
  logic [3:0] trapCycles;
  logic [3:0] next_trapCycles;

  always_comb begin
    next_trapCycles = 4'h0;
    if (savedWrite) begin
      next_trapCycles = 4'h1;
    end else if (busy && trapCycles != 4'h0) begin
      next_trapCycles = trapCycles + 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trapCycles <= 4'h0;
    end else begin
      trapCycles <= next_trapCycles;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  push_predec_a: assert property ((opReady && dec.pushOp
    && !(dec.privileged && !privMode))
    |=> memWrite && gprWrite && memAddr == gprWdata
        && memAddr == $past(destGprValue) - 32'h0000_0004)
    else $error("push did not predecrement by four");
  ctrl_two_cyc_a: assert property ((opReady && dec.pushOp && dec.minCycles == 4'h2
    && !(dec.privileged && !privMode)) |=> busy [*2])
    else $error("control push shorter than two cycles");
  sys_push_a: assert property ((opReady && dec.pushOp
    && dec.minCycles == sysreg_store_pkg::CYC_SYS) |=> busy ##1 (memWrite || !busy))
    else $error("multiply or link push held longer than its store");
  bank_priv_a: assert property ((opReady && dec.privileged && !privMode)
    |=> illegalInstr && !memWrite && !gprWrite)
    else $error("privileged store not suppressed in user mode");
  bank_data_a: assert property ((opReady && dec.srcSel == sysreg_store_pkg::SRC_BANK
    && dec.pushOp && privMode) |=> memWdata == bankedGpr[$past(dec.bankIdx)])
    else $error("banked push stored wrong register");

  trap_save_a: assert property ((opReady && dec.trapOp)
    |=> savedWrite && savedPc == $past(pcValue) && savedStatus == $past(statusWord)
        && softwareExceptionCode == $past(opcode[7:0]))
    else $error("trap did not save pc and code");
  trap_len_a: assert property ((opReady && dec.trapOp) |=> busy [*8] ##1 !busy)
    else $error("trap length not eight cycles");
  save_pulse_a: assert property (savedWrite |=> !savedWrite && busy)
    else $error("trap save strobe longer than one cycle");
  trap_count_a: assert property ((trapCycles != 4'h0 && !busy)
    |-> trapCycles == sysreg_store_pkg::CYC_TRAP)
    else $error("trap ended before or after eight cycles");

  load_stall_a: assert property ((hazard && !busy) |=> !busy && !gprWrite && !illegalInstr)
    else $error("load-use hazard not stalled");
  contend_hold_a: assert property ((memWrite && fetchRequest) |=> memWrite)
    else $error("store left bus during fetch contention");
  store_hold_a: assert property ((memWrite && !(memReady && !fetchRequest))
    |=> memWrite && $stable(memAddr) && $stable(memWdata))
    else $error("pending store changed before acceptance");
  reg_copy_a: assert property ((opReady && dec.regOp
    && !(dec.privileged && !privMode)) |=> gprWrite && !busy)
    else $error("register form not single cycle");

  disp_long_a: assert property ((dispMode == 2'h0 && operandSize == sysreg_store_pkg::SZ_LONG)
    |-> effAddr == dispBase + DATA_W'({dispField[3:0], 2'h0}))
    else $error("short displacement not scaled by four");
  disp_signed_a: assert property ((dispMode == 2'h3 && operandSize == sysreg_store_pkg::SZ_WORD)
    |-> effAddr == dispBase + {{(DATA_W-13){dispField[11]}}, dispField, 1'b0})
    else $error("long displacement not sign extended");

  push_cov: cover property (opReady && dec.pushOp ##1 memWrite);
  trap_cov: cover property (opReady && dec.trapOp);
  illegal_cov: cover property (illegalInstr);
  stall_cov: cover property (hazard);
  contend_cov: cover property (contend ##1 memWrite);
endmodule : system_register_store_decode
`default_nettype wire

// ===== tb.sv
// self-checking bench for the store decoder and trap control
// assumes the memory model on the store bus and one 50 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [31:0] DEST = 32'h8000_0100;
  logic        mclk = 1'b0, rst_n = 1'b0, opValid = 1'b0, privMode = 1'b1;
  logic        fetchRequest = 1'b0, loadPending = 1'b0;
  logic [15:0] opcode = 16'h0000;
  logic [3:0]  loadDestIdx = 4'h0, waitCycles = 4'h0, gprIdx;
  logic [11:0] dispField = 12'h000;
  logic [1:0]  dispMode = 2'h0, operandSize = 2'h0;
  logic [31:0] pcValue = 32'h0C00_0200, dispBase = 32'h0000_1000, destGprValue = DEST;
  logic [31:0] statusWord, globalBase, vectorBase, savedStatusIn, savedPcIn;
  logic [31:0] multiplyAccHigh, multiplyAccLow, returnLink, bank [8];
  logic        opReady, memReady, memWrite, gprWrite, savedWrite, illegalInstr, busy;
  logic [31:0] memAddr, memWdata, gprWdata, savedPc, savedStatus, effAddr, lastAddr, lastData;
  logic [7:0]  softwareExceptionCode, wrCount;
  int          errTotal = 0, nCompared = 0;

  always #10 mclk = ~mclk;

  system_register_store_decode #(.DATA_W(32)) dut (
    .mclk, .rst_n, .opcode, .opValid, .opReady, .privMode, .pcValue, .statusWord,
    .globalBase, .vectorBase, .savedStatusIn, .savedPcIn, .multiplyAccHigh, .multiplyAccLow,
    .returnLink, .bankedGpr(bank), .destGprValue, .fetchRequest, .loadPending, .loadDestIdx,
    .memReady, .memWrite, .memAddr, .memWdata, .gprWrite, .gprIdx, .gprWdata, .savedWrite,
    .savedPc, .savedStatus, .softwareExceptionCode, .illegalInstr, .busy, .dispField,
    .dispMode, .operandSize, .dispBase, .effAddr);

  mem_bus_model partner (.mclk, .rst_n, .memWrite, .memAddr, .memWdata, .fetchRequest,
    .waitCycles, .memReady, .lastAddr, .lastData, .wrCount);

  function automatic logic [31:0] srcOf(input int k);
    return {16'hA500, 8'(k), 8'h3C};
  endfunction : srcOf

  // k: 0..4 control, 5..7 multiply and link, 8..15 banks
  function automatic logic [15:0] opOf(input int k, input bit push, input logic [3:0] n);
    logic [3:0] hi;
    logic [3:0] lo;
    hi = (k < 5) ? 4'(k) : (k < 8) ? 4'(k - 5) : {1'b1, 3'(k - 8)};
    lo = (k >= 5 && k < 8) ? (push ? 4'h2 : 4'hA) : (push ? 4'h3 : 4'h2);
    return {push ? 4'h4 : 4'h0, n, hi, lo};
  endfunction : opOf

  task automatic print_verdict();
    if (errTotal == 0 && nCompared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic timeout();
    errTotal++;
    print_verdict();
  endtask : timeout

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // presents one instruction, returns at the negedge after the taking edge
  task automatic issue(input logic [15:0] op);
    int i;
    @(posedge mclk);
    opcode <= op;
    opValid <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(negedge mclk);
      if (opReady === 1'b1) break;
    end
    if (i == 40) timeout();
    @(posedge mclk);
    opValid <= 1'b0;
    @(negedge mclk);
  endtask : issue

  task automatic wait_idle();
    for (int i = 0; i < 40; i++) begin
      if (busy === 1'b0 && memWrite === 1'b0) return;
      @(negedge mclk);
    end
    timeout();
  endtask : wait_idle

  task automatic push_all();
    logic [7:0] cnt;
    for (int k = 0; k < 16; k++) begin
      cnt = wrCount;
      issue(opOf(k, 1'b1, 4'(k)));
      chk(memWrite, 32'h1);
      chk(memAddr, DEST - 32'h4);
      chk(memWdata, srcOf(k));
      chk(gprWrite, 32'h1);
      chk(gprIdx, 32'(k));
      chk(gprWdata, DEST - 32'h4);
      if (k < 5 || k > 7) begin
        @(negedge mclk);
        chk(busy, 32'h1);
      end
      wait_idle();
      chk(wrCount, cnt + 8'h01);
      chk(lastData, srcOf(k));
    end
  endtask : push_all

  task automatic reg_all();
    for (int k = 0; k < 16; k++) begin
      issue(opOf(k, 1'b0, 4'(15 - k)));
      chk(gprWrite, 32'h1);
      chk(gprIdx, 32'(15 - k));
      chk(gprWdata, srcOf(k));
      chk(memWrite, 32'h0);
      @(negedge mclk);
      chk(gprWrite, 32'h0);
    end
  endtask : reg_all

  task automatic trap_entry();
    int cnt;
    issue(16'hC35A);
    chk(savedWrite, 32'h1);
    chk(savedPc, pcValue);
    chk(savedStatus, statusWord);
    chk(softwareExceptionCode, 8'h5A);
    cnt = 0;
    while (busy === 1'b1 && cnt < 20) begin
      cnt++;
      @(negedge mclk);
    end
    chk(32'(cnt), 32'h8);
    chk(opReady, 32'h1);
  endtask : trap_entry

  task automatic store_contention();
    logic [7:0] cnt;
    cnt = wrCount;
    @(posedge mclk);
    fetchRequest <= 1'b1;
    waitCycles <= 4'h2;
    issue(opOf(6, 1'b1, 4'h3));
    repeat (4) begin
      chk(memWrite, 32'h1);
      chk(wrCount, cnt);
      @(negedge mclk);
    end
    @(posedge mclk);
    fetchRequest <= 1'b0;
    waitCycles <= 4'h0;
    wait_idle();
    chk(wrCount, cnt + 8'h01);
    chk(lastAddr, DEST - 32'h4);
    chk(lastData, srcOf(6));
  endtask : store_contention

  task automatic load_hazard();
    @(posedge mclk);
    loadPending <= 1'b1;
    loadDestIdx <= 4'h5;
    opcode <= opOf(6, 1'b1, 4'h5);
    opValid <= 1'b1;
    repeat (3) begin
      @(negedge mclk);
      chk(opReady, 32'h0);
      chk(memWrite, 32'h0);
    end
    @(posedge mclk);
    loadDestIdx <= 4'h9;
    @(negedge mclk);
    chk(opReady, 32'h1);
    @(posedge mclk);
    opValid <= 1'b0;
    loadPending <= 1'b0;
    @(negedge mclk);
    chk(memWrite, 32'h1);
    chk(gprIdx, 32'h5);
    wait_idle();
  endtask : load_hazard

  task automatic user_mode();
    @(posedge mclk);
    privMode <= 1'b0;
    issue(opOf(11, 1'b1, 4'h2));
    chk(illegalInstr, 32'h1);
    chk(memWrite, 32'h0);
    chk(gprWrite, 32'h0);
    @(negedge mclk);
    chk(illegalInstr, 32'h0);
    chk(memWrite, 32'h0);
    // status push is not privileged
    issue(opOf(0, 1'b1, 4'h2));
    chk(memWrite, 32'h1);
    wait_idle();
    @(posedge mclk);
    privMode <= 1'b1;
  endtask : user_mode

  task automatic disp_scale();
    logic [11:0] fld [4] = '{12'hFFF, 12'hFFF, 12'hF80, 12'h800};
    logic [1:0]  sz [4] = '{2'h2, 2'h1, 2'h0, 2'h1};
    logic [31:0] ex [4] = '{32'h0000_103C, 32'h0000_11FE, 32'h0000_0F80, 32'h0000_0000};
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      dispField <= fld[i];
      dispMode <= 2'(i);
      operandSize <= sz[i];
      @(negedge mclk);
      chk(effAddr, ex[i]);
    end
  endtask : disp_scale

  initial begin
    statusWord = srcOf(0);
    globalBase = srcOf(1);
    vectorBase = srcOf(2);
    savedStatusIn = srcOf(3);
    savedPcIn = srcOf(4);
    multiplyAccHigh = srcOf(5);
    multiplyAccLow = srcOf(6);
    returnLink = srcOf(7);
    for (int i = 0; i < 8; i++) bank[i] = srcOf(8 + i);
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    push_all();
    reg_all();
    trap_entry();
    store_contention();
    load_hazard();
    user_mode();
    disp_scale();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
